// File: gsoc_pkg.sv
`default_nettype none
package gsoc_pkg;
  // indicator colour codes
  localparam logic [2:0] LED_OFF = 3'h0;
  localparam logic [2:0] LED_YELLOW = 3'h1;
  localparam logic [2:0] LED_GREEN = 3'h2;
  localparam logic [2:0] LED_RED = 3'h3;
  localparam logic [2:0] LED_PURPLE = 3'h4;
  // timing
  localparam int CLK_HZ = 40000000;
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
  localparam int FEEDBACK_MS = 100;
  localparam int FEEDBACK_CYC = (CLK_HZ / 1000) * FEEDBACK_MS;
  localparam int SELFTEST_MS = 1000;
  localparam int SELFTEST_CYC = (CLK_HZ / 1000) * SELFTEST_MS;
  localparam int CNT_W = 32;
  // error codes on the indicator
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_OUTPUT = 2'h1;
  localparam logic [1:0] ERR_FEEDBACK = 2'h2;
  localparam logic [1:0] ERR_SUPPLY = 2'h3;
  localparam int CHAIN_MAX = 32;
  typedef enum {GSOC_OUTSIDE, GSOC_SAFE, GSOC_LIMIT, GSOC_PAIRING, GSOC_ERROR} gsoc_state_e;
endpackage : gsoc_pkg
`default_nettype wire

// File: gsoc_top.sv
// Summary of operation
// R1: outputs on only with inputs and safe zone
// R2: after reset outputs off, steady yellow
// R3: safe zone entry enables outputs, steady green
// R4: limit zone keeps outputs on, hysteresis
// R5: limit zone with outputs shows flashing yellow
// R6: leaving limit zone disables outputs, yellow
// R7: supervise supply, run cyclic self-tests
// R8: check outputs for faults while switching
// R9: feedback must change coherently with outputs
// R10: feedback is relay NC contact state
// R11: pairing input starts actuator re-pairing
// R12: signal output follows guard closed, variant polarity
// R13: inverted: signal active when actuator removed
// R14: evaluator monitors last sensor outputs
// R15: feedback variant terminates chain of 32
// R16: indicator shows sub-function states
// R17: errors give red coded indicator
// R18: pairing shows purple indicator
// R19: faults force outputs off until cleared
`default_nettype none
module gsoc_top #(
  parameter int FLASH_CYCLES = gsoc_pkg::FLASH_CYC,
  parameter int FEEDBACK_CYCLES = gsoc_pkg::FEEDBACK_CYC,
  parameter int SELFTEST_CYCLES = gsoc_pkg::SELFTEST_CYC
) (
  input wire logic sys_clk, // 40 MHz
  input wire logic reset_n, // sync, active low
  input wire logic safety_in_a, // upstream channel a
  input wire logic safety_in_b, // upstream channel b
  input wire logic inputs_present, // variant has safety inputs
  input wire logic in_safe_zone, // actuator in safe zone
  input wire logic in_limit_zone, // actuator in limit zone
  input wire logic supply_ok, // supply monitor level
  input wire logic selftest_pass, // internal test result
  input wire logic out_readback_a, // sensed level of out a
  input wire logic out_readback_b, // sensed level of out b
  input wire logic feedback_en, // contact monitoring variant
  input wire logic contact_feedback_in, // relay nc contacts, high = relays released
  input wire logic pairing_en, // programming input variant
  input wire logic pairing_request_in, // programming input
  input wire logic pairing_done, // identification finished
  input wire logic signal_invert, // inverted signalling variant
  input wire logic signal_active_closed, // standard polarity choice
  input wire logic fault_clear, // clears latched error
  output logic safety_out_a, // safety output a
  output logic safety_out_b, // safety output b
  output logic signal_out, // signalling output
  output logic pairing_active, // re-pairing in progress
  output logic selftest_req, // one-cycle self-test pulse
  output logic [2:0] led_colour, // indicator colour
  output logic [1:0] err_code // latched error type
);
  gsoc_pkg::gsoc_state_e state_q, state_d;
  logic outs_q, outs_d;
  logic sig_q, sig_d;
  logic [1:0] err_q, err_d;
  logic [2:0] led_q, led_d;
  logic [31:0] flash_q, flash_d;
  logic blink_q, blink_d;
  logic [31:0] fb_q, fb_d;
  logic [31:0] st_q, st_d;
  logic st_pulse_q, st_pulse_d;
  logic pair_req_q, pair_req_d;

  // variants without safety inputs behave as if both channels were good
  function automatic logic inputs_ok(input logic pres, input logic a, input logic b);
    inputs_ok = !pres || (a && b);
  endfunction : inputs_ok

  function automatic logic zone_held(input logic safe, input logic limit);
    zone_held = safe || limit;
  endfunction : zone_held

  logic in_ok;
  logic out_fault;
  logic fb_fault;
  logic sup_fault;
  logic pair_rise;

  always_comb begin
    in_ok = inputs_ok(inputs_present, safety_in_a, safety_in_b);
    // readback must match the commanded level on both channels
    out_fault = (out_readback_a != outs_q) || (out_readback_b != outs_q); // R8
    // feedback closed contacts mean relays released; must track outputs within a window
    fb_fault = feedback_en && (fb_q >= 32'(FEEDBACK_CYCLES)); // R9 R10
    sup_fault = !supply_ok || (st_pulse_q && !selftest_pass); // R7
    // history resets low, the idle level of the pin, so no false start after reset
    pair_rise = pairing_en && pairing_request_in && !pair_req_q; // R11
  end

  // main position and output control
  always_comb begin
    state_d = state_q;
    err_d = err_q;
    outs_d = 1'b0;
    case (state_q)
      gsoc_pkg::GSOC_OUTSIDE: begin
        if (in_safe_zone && in_ok) begin
          state_d = gsoc_pkg::GSOC_SAFE; // R3
        end
      end
      gsoc_pkg::GSOC_SAFE: begin
        // drop with the state change, not one cycle after it
        outs_d = in_ok && zone_held(in_safe_zone, in_limit_zone); // R1 R6
        if (!in_ok) begin
          state_d = gsoc_pkg::GSOC_OUTSIDE;
        end else if (!in_safe_zone) begin
          state_d = in_limit_zone ? gsoc_pkg::GSOC_LIMIT : gsoc_pkg::GSOC_OUTSIDE; // R4 R6
        end
      end
      gsoc_pkg::GSOC_LIMIT: begin
        // hysteresis: limit zone alone keeps the outputs up
        outs_d = in_ok && zone_held(in_safe_zone, in_limit_zone); // R4 R6
        if (!in_ok || !(in_limit_zone || in_safe_zone)) begin
          state_d = gsoc_pkg::GSOC_OUTSIDE; // R6
        end else if (in_safe_zone) begin
          state_d = gsoc_pkg::GSOC_SAFE;
        end
      end
      gsoc_pkg::GSOC_PAIRING: begin
        if (pairing_done) begin
          state_d = gsoc_pkg::GSOC_OUTSIDE; // R18
        end
      end
      gsoc_pkg::GSOC_ERROR: begin
        // leave only once every fault source is gone
        if (fault_clear && !sup_fault && !fb_fault && !(out_readback_a || out_readback_b)) begin
          state_d = gsoc_pkg::GSOC_OUTSIDE; // R19
          err_d = gsoc_pkg::ERR_NONE;
        end
      end
      default: state_d = gsoc_pkg::GSOC_OUTSIDE;
    endcase
    if (state_d != gsoc_pkg::GSOC_ERROR && state_q != gsoc_pkg::GSOC_ERROR) begin
      if (pair_rise && state_q != gsoc_pkg::GSOC_PAIRING) begin
        state_d = gsoc_pkg::GSOC_PAIRING; // R11
        outs_d = 1'b0;
      end
      // faults win over a pairing request raised in the same cycle
      if (sup_fault || out_fault || fb_fault) begin
        state_d = gsoc_pkg::GSOC_ERROR; // R17 R19
        outs_d = 1'b0;
        err_d = sup_fault ? gsoc_pkg::ERR_SUPPLY :
                out_fault ? gsoc_pkg::ERR_OUTPUT : gsoc_pkg::ERR_FEEDBACK;
      end
    end
  end

  // indicator, signalling, timers
  always_comb begin
    flash_d = (flash_q >= 32'(FLASH_CYCLES - 1)) ? 32'h0 : flash_q + 32'h1;
    blink_d = (flash_q >= 32'(FLASH_CYCLES - 1)) ? !blink_q : blink_q;
    // self-test keeps running in every state, error included
    st_pulse_d = (st_q >= 32'(SELFTEST_CYCLES - 1)); // R7
    st_d = st_pulse_d ? 32'h0 : st_q + 32'h1;
    pair_req_d = pairing_en && pairing_request_in;
    // contact should be closed when outputs off, open when on
    if (feedback_en && (contact_feedback_in == outs_q)) begin
      // saturating, so a stuck contact never wraps back to zero
      fb_d = (fb_q >= 32'(FEEDBACK_CYCLES)) ? fb_q : fb_q + 32'h1; // R9
    end else begin
      fb_d = 32'h0;
    end
    case (state_d)
      gsoc_pkg::GSOC_SAFE: led_d = gsoc_pkg::LED_GREEN; // R3 R16
      gsoc_pkg::GSOC_LIMIT: led_d = blink_q ? gsoc_pkg::LED_YELLOW : gsoc_pkg::LED_OFF; // R5
      gsoc_pkg::GSOC_PAIRING: led_d = gsoc_pkg::LED_PURPLE; // R18
      gsoc_pkg::GSOC_ERROR: begin
        // error type shown as red alternating with a code colour, steady red for a supply error
        led_d = (blink_q || err_d == gsoc_pkg::ERR_SUPPLY) ? gsoc_pkg::LED_RED :
                (err_d == gsoc_pkg::ERR_OUTPUT ? gsoc_pkg::LED_YELLOW :
                gsoc_pkg::LED_GREEN); // R17
      end
      default: led_d = gsoc_pkg::LED_YELLOW; // R2 R6
    endcase
    // inverted variant also proves the wiring: high only with outputs off
    if (signal_invert) begin
      sig_d = !outs_d && (state_d == gsoc_pkg::GSOC_OUTSIDE); // R13
    end else begin
      sig_d = outs_d ? signal_active_closed : !signal_active_closed; // R12
    end
  end

  // one register bank; every next value comes from the comb blocks above
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= gsoc_pkg::GSOC_OUTSIDE; // R2
      outs_q <= 1'b0;
      sig_q <= 1'b0;
      err_q <= gsoc_pkg::ERR_NONE;
      led_q <= gsoc_pkg::LED_YELLOW;
      flash_q <= 32'h0;
      blink_q <= 1'b0;
      fb_q <= 32'h0;
      st_q <= 32'h0;
      st_pulse_q <= 1'b0;
      pair_req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      outs_q <= outs_d;
      sig_q <= sig_d;
      err_q <= err_d;
      led_q <= led_d;
      flash_q <= flash_d;
      blink_q <= blink_d;
      fb_q <= fb_d;
      st_q <= st_d;
      st_pulse_q <= st_pulse_d;
      pair_req_q <= pair_req_d;
    end
  end

  // both channels share one command; redundancy lives in the readback check
  assign safety_out_a = outs_q; // R1 R15
  assign safety_out_b = outs_q;
  assign signal_out = sig_q;
  assign pairing_active = (state_q == gsoc_pkg::GSOC_PAIRING);
  assign selftest_req = st_pulse_q;
  assign led_colour = led_q;
  assign err_code = err_q;
endmodule : gsoc_top
`default_nettype wire

// File: gsoc_top_sva.sv
`default_nettype none
module gsoc_top_sva (
  input wire logic sys_clk, // clock
  input wire logic reset_n, // sync reset
  input wire logic safety_in_a, // chan a
  input wire logic safety_in_b, // chan b
  input wire logic in_safe_zone, // safe zone
  input wire logic in_limit_zone, // limit zone
  input wire logic supply_ok, // supply
  input wire logic out_readback_a, // sensed a
  input wire logic selftest_req, // test pulse
  input wire logic safety_out_a, // out a
  input wire logic safety_out_b, // out b
  input wire logic [1:0] err_code // error
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic ok = safety_in_a && safety_in_b && supply_ok && !selftest_req;
  a_outs_agree: assert property (safety_out_a == safety_out_b)
    else $error("outputs differ");
  a_rise_after_safe: assert property ($rose(safety_out_a) |-> $past(in_safe_zone, 2))
    else $error("output rose outside safe zone");
  a_limit_hold: assert property (safety_out_a && in_limit_zone && ok && out_readback_a
    && err_code == 2'h0 |=> safety_out_a)
    else $error("output dropped in limit zone");
  a_limit_drop: assert property (safety_out_a && !in_limit_zone && !in_safe_zone
    |=> !safety_out_a)
    else $error("output held outside zones");
  a_error_off: assert property (err_code != 2'h0 && $past(err_code) != 2'h0
    |-> !safety_out_a)
    else $error("output on in error");
  a_readback_err: assert property (safety_out_a && !out_readback_a && ok && err_code == 2'h0
    |-> ##[1:2] err_code == gsoc_pkg::ERR_OUTPUT)
    else $error("readback fault missed");
  a_supply_err: assert property (!supply_ok && err_code == 2'h0
    |-> ##[1:2] err_code == gsoc_pkg::ERR_SUPPLY)
    else $error("supply fault missed");
  a_test_pulse: assert property (selftest_req |=> !selftest_req)
    else $error("self-test pulse too long");
endmodule : gsoc_top_sva
bind gsoc_top gsoc_top_sva gsoc_top_sva_inst (.sys_clk(sys_clk), .reset_n(reset_n),
  .safety_in_a(safety_in_a), .safety_in_b(safety_in_b), .in_safe_zone(in_safe_zone),
  .in_limit_zone(in_limit_zone), .supply_ok(supply_ok), .out_readback_a(out_readback_a),
  .selftest_req(selftest_req), .safety_out_a(safety_out_a), .safety_out_b(safety_out_b),
  .err_code(err_code));
`default_nettype wire

// File: gsoc_relay_model.sv
`default_nettype none
module gsoc_relay_model (
  input wire logic sys_clk, // clock
  input wire logic safety_out_a, // from sensor
  input wire logic safety_out_b, // from sensor
  input wire logic short_a, // pull readback a low
  input wire logic stuck_fb, // nc contact stuck closed
  output logic out_readback_a, // sensed a
  output logic out_readback_b, // sensed b
  output var logic contact_feedback_in // nc contacts
);
  timeunit 1ns;
  timeprecision 100ps;
  assign out_readback_a = safety_out_a && !short_a;
  assign out_readback_b = safety_out_b;
  // relays release a cycle late, well inside the tolerance
  always_ff @(posedge sys_clk) begin
    contact_feedback_in <= stuck_fb || !(safety_out_a || safety_out_b);
  end
endmodule : gsoc_relay_model
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, reset_n = 1'b0, safety_in_a = 1'b1, safety_in_b = 1'b1;
  logic in_safe_zone = 1'b0, in_limit_zone = 1'b0, supply_ok = 1'b1, short_a = 1'b0;
  logic pairing_request_in = 1'b0, pairing_done = 1'b0, signal_invert = 1'b0;
  logic selftest_pass = 1'b1, feedback_en = 1'b1, signal_active_closed = 1'b1, stuck_fb = 1'b0;
  logic fault_clear = 1'b0, safety_out_a, safety_out_b, signal_out, pairing_active;
  logic selftest_req, out_readback_a, out_readback_b, contact_feedback_in, y, o;
  logic [2:0] led_colour;
  logic [1:0] err_code;
  int err_count = 0, n_checks = 0, cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  gsoc_top #(.FLASH_CYCLES(4), .FEEDBACK_CYCLES(8), .SELFTEST_CYCLES(16)) gsoc_top_inst (
    .sys_clk, .reset_n, .safety_in_a, .safety_in_b, .inputs_present(1'b1), .in_safe_zone,
    .in_limit_zone, .supply_ok, .selftest_pass, .out_readback_a, .out_readback_b,
    .feedback_en, .contact_feedback_in, .pairing_en(1'b1), .pairing_request_in,
    .pairing_done, .signal_invert, .signal_active_closed, .fault_clear,
    .safety_out_a, .safety_out_b, .signal_out, .pairing_active, .selftest_req, .led_colour,
    .err_code);
  gsoc_relay_model gsoc_relay_model_inst (.sys_clk, .safety_out_a, .safety_out_b, .short_a,
    .stuck_fb, .out_readback_a, .out_readback_b, .contact_feedback_in);
  task automatic chk(string nm, logic [2:0] exp, logic [2:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic t_zones();
    in_safe_zone = 1'b1;
    in_limit_zone = 1'b1;
    cyc(3);
    chk("out", 3'h1, 3'(safety_out_a));
    chk("led", gsoc_pkg::LED_GREEN, led_colour);
    chk("sig", 3'h1, 3'(signal_out));
    in_safe_zone = 1'b0;
    {y, o} = 2'b00;
    repeat (10) begin
      cyc(1);
      y |= led_colour === gsoc_pkg::LED_YELLOW;
      o |= led_colour === gsoc_pkg::LED_OFF;
    end
    chk("hold", 3'h1, 3'(safety_out_a));
    chk("flash", 3'h3, 3'({y, o}));
    in_limit_zone = 1'b0;
    cyc(3);
    chk("out", 3'h0, 3'(safety_out_a));
    chk("led", gsoc_pkg::LED_YELLOW, led_colour);
    chk("sig", 3'h0, 3'(signal_out));
  endtask : t_zones
  task automatic t_inputs();
    in_safe_zone = 1'b1;
    cyc(3);
    safety_in_b = 1'b0;
    cyc(2);
    chk("in", 3'h0, 3'(safety_out_b));
    safety_in_b = 1'b1;
    in_safe_zone = 1'b0;
    cyc(3);
  endtask : t_inputs
  task automatic t_fault(logic sup, logic [2:0] code);
    in_safe_zone = sup;
    cyc(3);
    short_a = sup;
    supply_ok = sup;
    cyc(4);
    chk("err", code, 3'(err_code));
    chk("out", 3'h0, 3'(safety_out_a));
    if (!sup) chk("led", gsoc_pkg::LED_RED, led_colour);
    {short_a, supply_ok, in_safe_zone, fault_clear} = 4'h5;
    cyc(2);
    fault_clear = 1'b0;
    cyc(3);
    chk("clr", 3'h0, 3'(err_code));
  endtask : t_fault
  task automatic t_selftest();
    selftest_pass = 1'b0;
    cyc(20);
    chk("test", 3'(gsoc_pkg::ERR_SUPPLY), 3'(err_code));
    chk("out", 3'h0, 3'(safety_out_a));
    {selftest_pass, fault_clear} = 2'b11;
    cyc(2);
    fault_clear = 1'b0;
    cyc(1);
    chk("clr", 3'h0, 3'(err_code));
  endtask : t_selftest
  task automatic t_feedback();
    {feedback_en, stuck_fb, in_safe_zone} = 3'b011;
    cyc(14);
    chk("fb_off", 3'h1, 3'(safety_out_a));
    feedback_en = 1'b1;
    cyc(5);
    chk("fb_win", 3'h1, 3'(safety_out_a));
    cyc(7);
    chk("err", 3'(gsoc_pkg::ERR_FEEDBACK), 3'(err_code));
    chk("out", 3'h0, 3'(safety_out_a));
    {stuck_fb, in_safe_zone, fault_clear} = 3'b001;
    cyc(2);
    fault_clear = 1'b0;
    cyc(1);
    chk("clr", 3'h0, 3'(err_code));
  endtask : t_feedback
  task automatic t_pair();
    pairing_request_in = 1'b1;
    cyc(3);
    chk("pair", 3'h1, 3'(pairing_active));
    chk("led", gsoc_pkg::LED_PURPLE, led_colour);
    {pairing_request_in, pairing_done} = 2'b01;
    cyc(1);
    pairing_done = 1'b0;
    cyc(3);
    chk("pair", 3'h0, 3'(pairing_active));
  endtask : t_pair
  task automatic t_invert();
    signal_active_closed = 1'b0;
    cyc(2);
    chk("pol", 3'h1, 3'(signal_out));
    signal_active_closed = 1'b1;
    signal_invert = 1'b1;
    cyc(3);
    chk("inv", 3'h1, 3'(signal_out));
    in_safe_zone = 1'b1;
    cyc(4);
    chk("inv", 3'h0, 3'(signal_out));
  endtask : t_invert
  always @(posedge sys_clk) begin
    cycles++;
    // whole run needs about 120 cycles
    if (cycles == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    cyc(4);
    reset_n = 1'b1;
    cyc(1);
    chk("rst", 3'h0, 3'(safety_out_a));
    chk("rst", gsoc_pkg::LED_YELLOW, led_colour);
    t_zones();
    t_inputs();
    t_fault(1'b1, 3'(gsoc_pkg::ERR_OUTPUT));
    t_fault(1'b0, 3'(gsoc_pkg::ERR_SUPPLY));
    t_selftest();
    t_feedback();
    t_pair();
    t_invert();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
